//--- exception_vector_table_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "vtmap_defs.svh"
module exception_vector_table_map #(
    parameter int NUM_PERIPH = 92
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clock_fail,
    input wire logic control_interrupt_expansion_err,
    input wire logic external_nonmaskable_pin_input,
    input wire logic nonmaskable_watchdog_timeout,
    input wire logic mem_access_err,
    input wire logic mem_access_precise,
    input wire logic ram_uncorrectable,
    input wire logic flash_uncorrectable,
    input wire logic vtor_wr_en,
    input wire logic vtor_wr_priv,
    input wire logic [31:0] vtor_wr_data,
    input wire logic lookup_req,
    input wire logic [6:0] lookup_vec,
    input wire logic [7:0] prio_wr_en_vec,
    input wire logic [6:0] prio_wr_vec,
    input wire logic [7:0] prio_wr_data,
    output logic [31:0] vector_base_offset_register,
    output logic vtor_reject,
    output logic boot_fetch_stack,
    output logic boot_fetch_reset,
    output logic [31:0] fetch_addr,
    output logic fetch_valid,
    output logic [6:0] fetch_vec,
    output logic nmi_req,
    output logic busfault_sync,
    output logic busfault_async,
    output logic [7:0] active_prio
);
    // ------------------------------------------------
    // state
    // ------------------------------------------------
    typedef struct packed {
        vtmap_pkg::fetch_state_e st;
        logic [6:0] vec;
        logic pend;
        logic [6:0] out_vec;
        logic nmi;
        logic pin_s1;
        logic pin_s2;
        logic bf_sync;
        logic bf_async;
        logic boot_stack;
        logic boot_reset;
        logic [7:0] prio;
        logic [NUM_PERIPH+15:0][7:0] prio_tab;
    } st_s;
    st_s s_q;
    st_s s_d;
    logic [31:0] base_w;
    logic reject_w;
    vtmap_if lk();
    // ------------------------------------------------
    // base register and address calculator
    // ------------------------------------------------
    vtmap_base_reg u_base (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_en(vtor_wr_en),
        .wr_priv(vtor_wr_priv),
        .wr_data(vtor_wr_data),
        .base_q(base_w),
        .reject_q(reject_w)
    );
    assign lk.base = base_w;
    assign lk.vec = s_q.vec;
    assign lk.req = s_q.pend;
    vtmap_addr_calc u_calc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .lk(lk)
    );
    // fixed and programmable priority of a vector
    function automatic logic [7:0] prio_of(input logic [6:0] v,
                                           input logic [NUM_PERIPH+15:0][7:0] t);
        logic [7:0] p;
        p = `PRIO_DEFAULT;
        case (v)
            `VEC_RESET: p = `PRIO_RESET; // RQ12
            `VEC_NMI: p = `PRIO_NMI; // RQ2
            `VEC_HARD: p = `PRIO_HARD; // RQ12
            default: begin
                if (v <= `VEC_PERIPH_LAST) p = t[v]; // RQ5
            end
        endcase
        return p;
    endfunction : prio_of
    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pend = 1'b0;
        s_d.boot_stack = 1'b0;
        s_d.boot_reset = 1'b0;
        // pin input through two flip-flops before use
        s_d.pin_s1 = external_nonmaskable_pin_input;
        s_d.pin_s2 = s_q.pin_s1;
        // nonmaskable sources
        s_d.nmi = clock_fail | control_interrupt_expansion_err
                | s_q.pin_s2 | nonmaskable_watchdog_timeout; // RQ2
        // bus fault sources, split by precision
        s_d.bf_sync = mem_access_err & mem_access_precise; // RQ3 RQ4
        s_d.bf_async = (mem_access_err & ~mem_access_precise)
                     | ram_uncorrectable | flash_uncorrectable; // RQ3 RQ4
        if (prio_wr_en_vec[0] && (prio_wr_vec > `VEC_HARD)
                && (prio_wr_vec <= `VEC_PERIPH_LAST)) begin
            s_d.prio_tab[prio_wr_vec] = prio_wr_data;
        end
        case (s_q.st)
            vtmap_pkg::FETCH_IDLE: begin
                s_d.vec = `VEC_STACK; // RQ1
                s_d.pend = 1'b1;
                s_d.st = vtmap_pkg::FETCH_STACK;
            end
            vtmap_pkg::FETCH_STACK: begin
                s_d.boot_stack = 1'b1; // stack word fetched this edge
                s_d.vec = `VEC_RESET; // RQ7
                s_d.pend = 1'b1;
                s_d.st = vtmap_pkg::FETCH_RESET_VEC;
            end
            vtmap_pkg::FETCH_RESET_VEC: begin
                s_d.boot_reset = 1'b1; // reset handler fetched this edge
                s_d.st = vtmap_pkg::FETCH_RUN;
            end
            vtmap_pkg::FETCH_RUN: begin
                if (s_q.nmi) begin
                    s_d.vec = `VEC_NMI; // RQ2
                    s_d.pend = 1'b1;
                end else if (s_q.bf_sync || s_q.bf_async) begin
                    s_d.vec = `VEC_BUSFAULT; // RQ3
                    s_d.pend = 1'b1;
                end else if (lookup_req) begin
                    s_d.vec = lookup_vec; // RQ6 RQ7
                    s_d.pend = 1'b1;
                end
            end
            default: s_d.st = vtmap_pkg::FETCH_IDLE;
        endcase
        // vector and priority line up with the fetched address
        if (s_q.pend) begin
            s_d.out_vec = s_q.vec;
            s_d.prio = prio_of(s_q.vec, s_q.prio_tab); // RQ2 RQ12
        end
    end
    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0; // RQ5 RQ8
        end else begin
            s_q <= s_d;
        end
    end
    // ------------------------------------------------
    // outputs, each from a flip-flop
    // ------------------------------------------------
    assign vector_base_offset_register = base_w;
    assign vtor_reject = reject_w;
    assign fetch_addr = lk.addr; // RQ12
    assign fetch_valid = lk.valid;
    assign fetch_vec = s_q.out_vec;
    assign boot_fetch_stack = s_q.boot_stack;
    assign boot_fetch_reset = s_q.boot_reset;
    assign nmi_req = s_q.nmi;
    assign busfault_sync = s_q.bf_sync;
    assign busfault_async = s_q.bf_async;
    assign active_prio = s_q.prio;
endmodule : exception_vector_table_map
`default_nettype wire

//--- exception_vector_table_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exception_vector_table_map_tb;
    logic clk_sys, sys_rst, go, run, vtor_wr_en, vtor_wr_priv, lookup_req, fetch_valid;
    logic nmi_req, bs, ba, vtor_reject;
    logic [3:0] nsrc, bf;
    logic [6:0] want, lookup_vec;
    logic [31:0] vtor_wr_data, base, fetch_addr, bm, r;
    logic [31:0] q[$];
    logic [31:0] wt[6] = '{32'h200, 32'h3FFFFE00, 32'h3FFFFE01, 32'h1FF, 32'h400, 32'h12345};
    int n_fail = 0;
    int cmp_count = 0;
    exception_vector_table_map exception_vector_table_map_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .clock_fail(nsrc[0]), .control_interrupt_expansion_err(nsrc[1]),
        .external_nonmaskable_pin_input(nsrc[2]), .nonmaskable_watchdog_timeout(nsrc[3]),
        .mem_access_err(bf[0]), .mem_access_precise(bf[1]), .ram_uncorrectable(bf[2]),
        .flash_uncorrectable(bf[3]), .vtor_wr_en(vtor_wr_en), .vtor_wr_priv(vtor_wr_priv),
        .vtor_wr_data(vtor_wr_data), .lookup_req(lookup_req), .lookup_vec(lookup_vec),
        .prio_wr_en_vec(8'h00), .prio_wr_vec(7'h00), .prio_wr_data(8'h00),
        .vector_base_offset_register(base), .vtor_reject(vtor_reject), .boot_fetch_stack(),
        .boot_fetch_reset(), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
        .fetch_vec(), .nmi_req(nmi_req), .busfault_sync(bs), .busfault_async(ba),
        .active_prio());
    vtmap_core_model vtmap_core_model_i (.clk_sys(clk_sys), .go(go), .want(want),
        .lookup_req(lookup_req), .lookup_vec(lookup_vec));
    // ----
    // clock, tasks and checks
    // ----
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // base write, expected base tracked in bm
    task automatic wr(input logic p, input logic [31:0] d);
        logic ok;
        ok = p && d >= 32'h200 && d <= 32'h3FFFFE00;
        {vtor_wr_en, vtor_wr_priv, vtor_wr_data} = {1'b1, p, d};
        tick;
        vtor_wr_en = 1'b0;
        if (ok) bm = d & 32'hFFFFFE00;
        chk(base, bm);
        chk(vtor_reject, !ok);
        tick;
    endtask : wr
    // lookup through the core model, expected address queued
    task automatic look(input logic [6:0] v);
        {go, want} = {1'b1, v};
        if (v <= 7'h6B) q.push_back(bm + {23'h0, v, 2'h0});
        tick;
    endtask : look
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // answer monitor, oldest queued address against each fetch
    always @(negedge clk_sys)
        if (run && fetch_valid === 1'b1)
            chk(fetch_addr, q.size() > 0 ? q.pop_front() : ~fetch_addr);
    // watchdog, far beyond the few hundred cycles of the tests
    initial begin
        #100000;
        n_fail++;
        complete_run;
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {go, run, nsrc, bf, vtor_wr_en, vtor_wr_priv, want, vtor_wr_data, bm} = '0;
        r = 32'h6762;
        repeat (16) tick;
        sys_rst = 1'b0;
        repeat (8) tick;
        chk(base, 32'h0);
        run = 1'b1;
        for (int i = 0; i < 26; i++) begin
            r = lfsr(r);
            wr(i < 20 ? r[0] : i != 24, i < 20 ? r & 32'h7FFFFFFF : wt[i - 20]);
        end
        $display("base writes done");
        for (int v = 1; v < 109; v++) look(7'(v));
        go = 1'b0;
        repeat (4) tick;
        chk(q.size(), 0);
        $display("lookups done");
        // one-edge source pulses, the pin source passes two extra flip-flops
        for (int i = 0; i < 4; i++) begin
            nsrc = 4'h1 << i;
            q.push_back(bm + 32'h8);
            tick;
            nsrc = 4'h0;
            if (i == 2) repeat (2) tick;
            chk(nmi_req, 1'b1);
            tick;
            chk(nmi_req, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            bf = 4'(i);
            if (bf[0] | bf[2] | bf[3]) q.push_back(bm + 32'h14);
            tick;
            chk({bs, ba}, {bf[0] & bf[1], bf[0] & !bf[1] | bf[2] | bf[3]});
        end
        bf = 4'h0;
        repeat (3) tick;
        chk(q.size(), 0);
        $display("faults done");
        {run, sys_rst} = 2'b01;
        tick;
        sys_rst = 1'b0;
        chk(base, 32'h0);
        bm = 32'h0;
        repeat (6) tick;
        run = 1'b1;
        look(7'h02);
        look(7'h05);
        go = 1'b0;
        repeat (4) tick;
        chk(q.size(), 0);
        $display("second reset done");
        complete_run;
    end
endmodule : exception_vector_table_map_tb
`default_nettype wire

//--- vtmap_addr_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "vtmap_defs.svh"
module vtmap_addr_calc (
    input wire logic clk_sys,
    input wire logic sys_rst,
    vtmap_if.calc lk
);
    typedef struct packed {
        logic [31:0] addr;
        logic valid;
    } st_s;
    st_s s_q;
    st_s s_d;
    // base plus four times vector, numbers above 107 get no valid
    always_comb begin
        s_d.addr = lk.base + {23'h000000, lk.vec, 2'b00}; // RQ12 RQ6 RQ7
        s_d.valid = lk.req && (lk.vec <= `VEC_PERIPH_LAST); // only a real request answers
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '{addr: `BASE_RESET, valid: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign lk.addr = s_q.addr;
    assign lk.valid = s_q.valid;
endmodule : vtmap_addr_calc
`default_nettype wire

//--- vtmap_base_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "vtmap_defs.svh"
module vtmap_base_reg (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic wr_priv,
    input wire logic [31:0] wr_data,
    output logic [31:0] base_q,
    output logic reject_q
);
    typedef struct packed {
        logic [31:0] base;
        logic reject;
    } st_s;
    st_s s_q;
    st_s s_d;
    logic in_range;
    // --------------------------------
    // range and alignment check
    // --------------------------------
    always_comb begin
        in_range = (wr_data >= `BASE_MIN) && (wr_data <= `BASE_MAX); // RQ9
        s_d = s_q;
        s_d.reject = 1'b0;
        if (wr_en) begin
            if (wr_priv && in_range) begin // RQ11
                s_d.base = {wr_data[31:`BASE_ALIGN_BITS], 9'h000}; // RQ10
            end else begin
                s_d.reject = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '{base: `BASE_RESET, reject: 1'b0}; // RQ8
        end else begin
            s_q <= s_d;
        end
    end
    assign base_q = s_q.base;
    assign reject_q = s_q.reject;
endmodule : vtmap_base_reg
`default_nettype wire

//--- vtmap_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core side issuing vector lookups
module vtmap_core_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [6:0] want,
    output logic lookup_req,
    output logic [6:0] lookup_vec
);
    initial {lookup_req, lookup_vec} = '0;
    // launch just after the edge, scramble the vector while idle
    always @(posedge clk_sys) begin
        lookup_req <= #1 go;
        lookup_vec <= #1 go ? want : ~lookup_vec;
    end
endmodule : vtmap_core_model
`default_nettype wire

//--- vtmap_defs.svh
// How it works
// [RQ1] reset fetch takes the initial stack pointer from table entry zero
// [RQ2] nonmaskable uses vector 2, offset 0x8, priority -2, four raising sources
// [RQ3] bus fault uses vector 5, offset 0x14, precise sync, imprecise async
// [RQ4] memory access error or uncorrectable ram or flash error raises bus fault
// [RQ5] all programmable priorities leave reset at value 0
// [RQ6] peripheral vectors 16 to 107 each own a slot relative to base
// [RQ7] system vectors 1 to 15 each own a slot relative to base
// [RQ8] any system reset forces the table base to zero
// [RQ9] relocated base must lie between 0x200 and 0x3FFFFE00 inclusive
// [RQ10] base offset is a multiple of 512, low nine bits zero
// [RQ11] only privileged writes may change the table base
// [RQ12] handler fetched at base plus four times vector; reset -3, hard fault -1
`ifndef VTMAP_DEFS_SVH
`define VTMAP_DEFS_SVH
`define VEC_STACK 7'h00
`define VEC_RESET 7'h01
`define VEC_NMI 7'h02
`define VEC_HARD 7'h03
`define VEC_MEMMGT 7'h04
`define VEC_BUSFAULT 7'h05
`define VEC_USAGE 7'h06
`define VEC_SVCALL 7'h0B
`define VEC_DEBUG 7'h0C
`define VEC_PENDSV 7'h0E
`define VEC_SYSTICK 7'h0F
`define VEC_PERIPH_FIRST 7'h10
`define VEC_PERIPH_LAST 7'h6B
`define OFS_NMI 32'h0000_0008
`define OFS_BUSFAULT 32'h0000_0014
`define BASE_RESET 32'h0000_0000
`define BASE_MIN 32'h0000_0200
`define BASE_MAX 32'h3FFF_FE00
`define BASE_ALIGN_BITS 9
`define PRIO_RESET 8'shFD
`define PRIO_NMI 8'shFE
`define PRIO_HARD 8'shFF
`define PRIO_DEFAULT 8'h00
`endif

//--- vtmap_if.sv
`timescale 1ns/1ps
`default_nettype none
// base register to lookup unit
interface vtmap_if;
    logic [31:0] base;
    logic [6:0] vec;
    logic [31:0] addr;
    logic req;
    logic valid;
    modport src(output base, output vec, output req, input addr, input valid);
    modport calc(input base, input vec, input req, output addr, output valid);
endinterface : vtmap_if
`default_nettype wire

//--- vtmap_pkg.sv
package vtmap_pkg;
    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_STACK,
        FETCH_RESET_VEC,
        FETCH_RUN
    } fetch_state_e;
    typedef logic [6:0] vec_num_t;
endpackage : vtmap_pkg

//--- vtmap_props.sv
`timescale 1ns/1ps
`default_nettype none
module vtmap_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clock_fail,
    input wire logic control_interrupt_expansion_err,
    input wire logic external_nonmaskable_pin_input,
    input wire logic nonmaskable_watchdog_timeout,
    input wire logic mem_access_err,
    input wire logic mem_access_precise,
    input wire logic ram_uncorrectable,
    input wire logic flash_uncorrectable,
    input wire logic vtor_wr_en,
    input wire logic vtor_wr_priv,
    input wire logic [31:0] vtor_wr_data,
    input wire logic lookup_req,
    input wire logic [6:0] lookup_vec,
    input wire logic [31:0] vector_base_offset_register,
    input wire logic vtor_reject,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [6:0] fetch_vec,
    input wire logic nmi_req,
    input wire logic busfault_sync,
    input wire logic busfault_async,
    input wire logic boot_fetch_stack,
    input wire logic boot_fetch_reset,
    input wire logic [7:0] active_prio
);
    // ----
    // helper terms and checks
    // ----
    wire logic nmi_direct = clock_fail | control_interrupt_expansion_err
        | nonmaskable_watchdog_timeout;
    wire logic bf_pre = mem_access_err & mem_access_precise;
    wire logic bf_imp = mem_access_err & !mem_access_precise | ram_uncorrectable
        | flash_uncorrectable;
    wire logic wr_bad = vtor_wr_en & (!vtor_wr_priv | (vtor_wr_data < 32'h200)
        | (vtor_wr_data > 32'h3FFFFE00));
    wire logic busy = nmi_req | busfault_sync | busfault_async;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    nmi_src_a: assert property (1'b1 |=> nmi_req ==
        ($past(nmi_direct) | $past(external_nonmaskable_pin_input, 3)))
        else $error("nmi mismatch");
    bf_sync_a: assert property (1'b1 |=> busfault_sync == $past(bf_pre))
        else $error("sync fault mismatch");
    bf_async_a: assert property (1'b1 |=> busfault_async == $past(bf_imp))
        else $error("async fault mismatch");
    wr_refuse_a: assert property (wr_bad |=> vtor_reject
        && $stable(vector_base_offset_register)) else $error("bad write taken");
    wr_load_a: assert property (vtor_wr_en && !wr_bad |=> !vtor_reject
        && vector_base_offset_register == ($past(vtor_wr_data) & 32'hFFFFFE00))
        else $error("write not loaded");
    base_rst_a: assert property ($fell(sys_rst) |-> vector_base_offset_register == 0)
        else $error("base not cleared");
    fetch_addr_a: assert property (fetch_valid |-> fetch_addr ==
        vector_base_offset_register + {23'h0, fetch_vec, 2'h0}) else $error("bad address");
    fetch_lat_a: assert property (lookup_req && lookup_vec <= 7'h6B && !busy |->
        ##2 fetch_valid && fetch_vec == $past(lookup_vec, 2)) else $error("no answer");
    boot_seq_a: assert property ($fell(sys_rst) |-> ##2 boot_fetch_stack && fetch_valid
        && fetch_vec == 7'h00 ##1 boot_fetch_reset && fetch_valid && fetch_vec == 7'h01
        && active_prio == 8'hFD) else $error("boot fetch order");
    prio_def_a: assert property (fetch_valid && fetch_vec > 7'h03 |->
        active_prio == 8'h00) else $error("priority not default");
    prio_nmi_a: assert property (fetch_valid && fetch_vec == 7'h02 |->
        active_prio == 8'hFE) else $error("nmi priority");
    cover property (fetch_valid);
    cover property (vtor_reject);
    cover property (nmi_req);
    cover property (busfault_sync);
endmodule : vtmap_props
bind exception_vector_table_map vtmap_props vtmap_props_i (.*);
`default_nettype wire
